// [rtl/sxs_pkg.sv]
// Purpose: constants for the system register set and state save logic
// Assumes: 32-bit registers addressed by a 5-bit system register number
// Notes:   status word bits 31 to 8 and pc bits 31 to 26 hold zero
// Behaviour
// - numbers 0-3 select irq and nmi save pairs
// - number 4 selects exception source, store only
// - number 5 selects status word, read and write
// - 16,17 table-call save pair; 20 base pointer
// - debug save pair only inside debug trap window
// - exception or irq saves pc and status word
// - saved irq pc is next instruction address
// - nmi saves into nmi pair, irq pair untouched
// - saved nmi pc is next instruction address
// - irq save pair upper bits read zero
// - nmi save pair upper bits read zero
// - return from irq restores irq save pair
// - return from nmi restores nmi save pair
// - restored pc drops bit 0
// - taken event loads its code into source register
// - source register ignores load instruction writes
// - pc keeps only low 26 bits
// - status bit 7 set by nmi, blocks nesting
// - status word load takes effect right after
package sxs_pkg;
  localparam logic [4:0]  SXS_NUM_IRQ_PC     = 5'h00;
  localparam logic [4:0]  SXS_NUM_IRQ_ST     = 5'h01;
  localparam logic [4:0]  SXS_NUM_NMI_PC     = 5'h02;
  localparam logic [4:0]  SXS_NUM_NMI_ST     = 5'h03;
  localparam logic [4:0]  SXS_NUM_SRC        = 5'h04;
  localparam logic [4:0]  SXS_NUM_PSW        = 5'h05;
  localparam logic [4:0]  SXS_NUM_TC_PC      = 5'h10;
  localparam logic [4:0]  SXS_NUM_TC_ST      = 5'h11;
  localparam logic [4:0]  SXS_NUM_DBG_PC     = 5'h12;
  localparam logic [4:0]  SXS_NUM_DBG_ST     = 5'h13;
  localparam logic [4:0]  SXS_NUM_TC_BASE    = 5'h14;
  localparam logic [31:0] SXS_PC_MASK        = 32'h03ff_fffe;
  localparam logic [31:0] SXS_SAVE_PC_MASK   = 32'h03ff_ffff;
  localparam logic [31:0] SXS_ST_MASK        = 32'h0000_00ff;
  localparam int          SXS_NP_BIT         = 7;
  localparam int          SXS_EP_BIT         = 6;
  localparam int          SXS_ID_BIT         = 5;
  localparam logic [31:0] SXS_PSW_RESET      = 32'h0000_0020;
  localparam logic [31:0] SXS_ZERO           = 32'h0000_0000;
  typedef enum logic [1:0] {
    SXS_EV_NONE = 2'b00,
    SXS_EV_IRQ  = 2'b01,
    SXS_EV_NMI  = 2'b10
  } sxs_ev_e;
endpackage

// [rtl/sxs_save_pair.sv]
// Purpose: one pc/status save pair, loaded by hardware or by software
// Assumes: hardware save and software write never in the same cycle
// Notes:   upper bits are masked on every load so they always read zero
`timescale 1ns/1ps
`default_nettype none
module sxs_save_pair
  import sxs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // hardware capture
  input  wire logic        save,
  input  wire logic [31:0] save_pc,
  input  wire logic [31:0] save_st,
  // software writes
  input  wire logic        wr_pc,
  input  wire logic        wr_st,
  input  wire logic [31:0] wr_data,
  // contents
  output logic      [31:0] pc_q,
  output logic      [31:0] st_q
);
  // hardware save wins; a write then would be lost anyway
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= SXS_ZERO;
      st_q <= SXS_ZERO;
    end else if (save) begin
      pc_q <= save_pc & SXS_SAVE_PC_MASK;
      st_q <= save_st & SXS_ST_MASK;
    end else begin
      if (wr_pc) begin
        pc_q <= wr_data & SXS_SAVE_PC_MASK;
      end
      if (wr_st) begin
        st_q <= wr_data & SXS_ST_MASK;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/sxs_sysreg.sv]
// Purpose: system register set with state save and restore on events
// Assumes: pipeline gives one-cycle strobes; next pc supplied by pipeline
// Notes:   reserved numbers read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module sxs_sysreg
  import sxs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // system register instructions
  input  wire logic        ld_en,
  input  wire logic        st_en,
  input  wire logic [4:0]  reg_num,
  input  wire logic [31:0] ld_data,
  output logic      [31:0] st_data,
  // current pc from the pipeline (address of next instruction)
  input  wire logic [31:0] next_pc,
  // events
  input  wire logic        irq_take,
  input  wire logic        nmi_take,
  input  wire logic [15:0] exc_code,
  input  wire logic        return_from_interrupt_instr_en,
  input  wire logic        dbg_enter,
  input  wire logic        dbg_return,
  // flag update from pipeline; flags and restore target to pipeline
  input  wire logic [31:0] flag_update,
  input  wire logic        flag_update_en,
  output logic      [31:0] psw_out,
  output logic             nmi_blocks,
  output logic             restore_en,
  output logic      [31:0] restore_pc
);
  logic [31:0] psw_q;
  logic [31:0] psw_d;
  logic [31:0] src_q;
  logic        dbg_win_q;
  logic [31:0] irq_pc;
  logic [31:0] irq_st;
  logic [31:0] nmi_pc;
  logic [31:0] nmi_st;
  logic [31:0] tc_pc;
  logic [31:0] tc_st;
  logic [31:0] dbg_pc;
  logic [31:0] dbg_st;
  logic [31:0] tc_base_q;
  logic        irq_ev;
  logic        nmi_ev;
  logic        ld_ok;
  logic        np_set;
  sxs_ev_e     ev;

  // nmi has priority; a blocked maskable request is dropped here
  always_comb begin
    if (nmi_take && !psw_q[SXS_NP_BIT]) begin
      ev = SXS_EV_NMI;
    end else if (irq_take && !psw_q[SXS_NP_BIT]) begin
      ev = SXS_EV_IRQ;
    end else begin
      ev = SXS_EV_NONE;
    end
  end
  assign nmi_ev = (ev == SXS_EV_NMI);
  assign irq_ev = (ev == SXS_EV_IRQ);
  assign np_set = psw_q[SXS_NP_BIT];
  assign ld_ok  = ld_en && !irq_ev && !nmi_ev && !return_from_interrupt_instr_en;

  // save pairs; next_pc is the address after the current one
  sxs_save_pair u_irq (
    .clk     (clk),
    .rst     (rst),
    .save    (irq_ev),
    .save_pc (next_pc),
    .save_st (psw_q),
    .wr_pc   (ld_ok && reg_num == SXS_NUM_IRQ_PC),
    .wr_st   (ld_ok && reg_num == SXS_NUM_IRQ_ST),
    .wr_data (ld_data),
    .pc_q    (irq_pc),
    .st_q    (irq_st)
  );
  sxs_save_pair u_nmi (
    .clk     (clk),
    .rst     (rst),
    .save    (nmi_ev),
    .save_pc (next_pc),
    .save_st (psw_q),
    .wr_pc   (ld_ok && reg_num == SXS_NUM_NMI_PC),
    .wr_st   (ld_ok && reg_num == SXS_NUM_NMI_ST),
    .wr_data (ld_data),
    .pc_q    (nmi_pc),
    .st_q    (nmi_st)
  );
  sxs_save_pair u_tc (
    .clk     (clk),
    .rst     (rst),
    .save    (1'b0),
    .save_pc (SXS_ZERO),
    .save_st (SXS_ZERO),
    .wr_pc   (ld_ok && reg_num == SXS_NUM_TC_PC),
    .wr_st   (ld_ok && reg_num == SXS_NUM_TC_ST),
    .wr_data (ld_data),
    .pc_q    (tc_pc),
    .st_q    (tc_st)
  );
  sxs_save_pair u_dbg (
    .clk     (clk),
    .rst     (rst),
    .save    (1'b0),
    .save_pc (SXS_ZERO),
    .save_st (SXS_ZERO),
    .wr_pc   (ld_ok && dbg_win_q && reg_num == SXS_NUM_DBG_PC),
    .wr_st   (ld_ok && dbg_win_q && reg_num == SXS_NUM_DBG_ST),
    .wr_data (ld_data),
    .pc_q    (dbg_pc),
    .st_q    (dbg_st)
  );

  // debug window opens on trap or illegal opcode, closes on return
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dbg_win_q <= 1'b0;
    end else if (dbg_enter) begin
      dbg_win_q <= 1'b1;
    end else if (dbg_return) begin
      dbg_win_q <= 1'b0;
    end
  end

  // table-call base pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tc_base_q <= SXS_ZERO;
    end else if (ld_ok && reg_num == SXS_NUM_TC_BASE) begin
      tc_base_q <= ld_data;
    end
  end

  // source register: only events load it, load writes are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_q <= SXS_ZERO;
    end else if (irq_ev || nmi_ev) begin
      src_q <= {16'h0000, exc_code};
    end
  end

  // next status word: events, return, load, then pipeline flags
  always_comb begin
    psw_d = psw_q;
    if (nmi_ev) begin
      psw_d[SXS_NP_BIT] = 1'b1;
      psw_d[SXS_ID_BIT] = 1'b1;
    end else if (irq_ev) begin
      psw_d[SXS_ID_BIT] = 1'b1;
    end else if (return_from_interrupt_instr_en) begin
      psw_d = np_set ? nmi_st : irq_st;
    end else if (ld_ok && reg_num == SXS_NUM_PSW) begin
      psw_d = ld_data;
    end else if (flag_update_en) begin
      psw_d = flag_update;
    end
    psw_d = psw_d & SXS_ST_MASK;
  end

  // the new word is visible the cycle after the load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psw_q <= SXS_PSW_RESET;
    end else begin
      psw_q <= psw_d;
    end
  end

  // restore target; bit 0 and upper bits dropped
  assign restore_en = return_from_interrupt_instr_en;
  assign restore_pc = (np_set ? nmi_pc : irq_pc) & SXS_PC_MASK;
  assign psw_out    = psw_q;
  assign nmi_blocks = np_set;

  // read path; reserved numbers read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_data <= SXS_ZERO;
    end else if (st_en) begin
      if (reg_num == SXS_NUM_IRQ_PC) begin
        st_data <= irq_pc;
      end else if (reg_num == SXS_NUM_IRQ_ST) begin
        st_data <= irq_st;
      end else if (reg_num == SXS_NUM_NMI_PC) begin
        st_data <= nmi_pc;
      end else if (reg_num == SXS_NUM_NMI_ST) begin
        st_data <= nmi_st;
      end else if (reg_num == SXS_NUM_SRC) begin
        st_data <= src_q;
      end else if (reg_num == SXS_NUM_PSW) begin
        st_data <= psw_q;
      end else if (reg_num == SXS_NUM_TC_PC) begin
        st_data <= tc_pc;
      end else if (reg_num == SXS_NUM_TC_ST) begin
        st_data <= tc_st;
      end else if (reg_num == SXS_NUM_DBG_PC && dbg_win_q) begin
        st_data <= dbg_pc;
      end else if (reg_num == SXS_NUM_DBG_ST && dbg_win_q) begin
        st_data <= dbg_st;
      end else if (reg_num == SXS_NUM_TC_BASE) begin
        st_data <= tc_base_q;
      end else begin
        st_data <= SXS_ZERO;
      end
    end
  end

  // checks on event saving
  a_irq_save_pc: assert property (@(posedge clk)
    disable iff (rst)
    irq_ev |=> irq_pc == ($past(next_pc) & SXS_SAVE_PC_MASK))
    else $error("irq save pc wrong");
  a_irq_save_st: assert property (@(posedge clk)
    disable iff (rst)
    irq_ev |=> irq_st == ($past(psw_q) & SXS_ST_MASK))
    else $error("irq save status wrong");
  a_nmi_save_pc: assert property (@(posedge clk)
    disable iff (rst)
    nmi_ev |=> nmi_pc == ($past(next_pc) & SXS_SAVE_PC_MASK))
    else $error("nmi save pc wrong");
  a_nmi_save_st: assert property (@(posedge clk)
    disable iff (rst)
    nmi_ev |=> nmi_st == ($past(psw_q) & SXS_ST_MASK))
    else $error("nmi save status wrong");
  a_nmi_keep_irq: assert property (@(posedge clk)
    disable iff (rst)
    nmi_ev |=> $stable(irq_pc) && $stable(irq_st))
    else $error("nmi disturbed irq pair");
  a_nmi_sets_np: assert property (@(posedge clk)
    disable iff (rst)
    nmi_ev |=> psw_q[SXS_NP_BIT])
    else $error("np not set on nmi");
  a_np_blocks: assert property (@(posedge clk)
    disable iff (rst)
    np_set && (irq_take || nmi_take) |=> $stable(src_q))
    else $error("event taken while nmi in service");
  a_src_load: assert property (@(posedge clk)
    disable iff (rst)
    (irq_ev || nmi_ev) |=> src_q[15:0] == $past(exc_code))
    else $error("source code not loaded");
  a_src_readonly: assert property (@(posedge clk)
    disable iff (rst)
    !(irq_ev || nmi_ev) |=> $stable(src_q))
    else $error("source register changed");

  // checks on the reserved upper bits
  a_irq_upper_zero: assert property (@(posedge clk)
    disable iff (rst)
    irq_pc[31:26] == 6'h00 && irq_st[31:8] == 24'h000000)
    else $error("irq pair upper bits set");
  a_nmi_upper_zero: assert property (@(posedge clk)
    disable iff (rst)
    nmi_pc[31:26] == 6'h00 && nmi_st[31:8] == 24'h000000)
    else $error("nmi pair upper bits set");
  a_pc_width: assert property (@(posedge clk)
    disable iff (rst)
    restore_pc[31:26] == 6'h00)
    else $error("restore pc above bit 25");

  // checks on register loads and reads
  a_irq_pc_load: assert property (@(posedge clk)
    disable iff (rst)
    ld_ok && reg_num == SXS_NUM_IRQ_PC |=>
      irq_pc == ($past(ld_data) & SXS_SAVE_PC_MASK))
    else $error("irq save pc load lost");
  a_tc_base_load: assert property (@(posedge clk)
    disable iff (rst)
    ld_ok && reg_num == SXS_NUM_TC_BASE |=> tc_base_q == $past(ld_data))
    else $error("base pointer load lost");
  a_psw_load: assert property (@(posedge clk)
    disable iff (rst)
    ld_ok && reg_num == SXS_NUM_PSW |=>
      psw_q == ($past(ld_data) & SXS_ST_MASK))
    else $error("status load not visible");
  a_psw_read: assert property (@(posedge clk)
    disable iff (rst)
    st_en && reg_num == SXS_NUM_PSW |=> st_data == $past(psw_q))
    else $error("status word read wrong");
  a_src_read: assert property (@(posedge clk)
    disable iff (rst)
    st_en && reg_num == SXS_NUM_SRC |=> st_data == $past(src_q))
    else $error("source register read wrong");
  a_dbg_sealed: assert property (@(posedge clk)
    disable iff (rst)
    !dbg_win_q |=> $stable(dbg_pc) && $stable(dbg_st))
    else $error("debug pair changed outside window");
  a_dbg_read_zero: assert property (@(posedge clk)
    disable iff (rst)
    st_en && !dbg_win_q &&
      (reg_num == SXS_NUM_DBG_PC || reg_num == SXS_NUM_DBG_ST) |=>
      st_data == SXS_ZERO)
    else $error("debug pair readable outside window");

  // checks on the return path
  a_return_from_interrupt_instr_psw: assert property (@(posedge clk)
    disable iff (rst)
    return_from_interrupt_instr_en && !nmi_ev && !irq_ev |=>
      psw_q == $past(np_set ? nmi_st : irq_st))
    else $error("return restored wrong status");
  a_return_from_interrupt_instr_irq_psw: assert property (@(posedge clk)
    disable iff (rst)
    return_from_interrupt_instr_en && !np_set && !irq_ev && !nmi_ev |=>
      psw_q == $past(irq_st))
    else $error("return status not from irq pair");
  a_restore_even: assert property (@(posedge clk)
    disable iff (rst)
    restore_en |-> restore_pc[0] == 1'b0 && restore_pc[31:26] == 6'h00)
    else $error("restore pc not masked");
  a_restore_irq: assert property (@(posedge clk)
    disable iff (rst)
    restore_en && !np_set |->
      restore_pc == {6'h00, irq_pc[25:1], 1'b0})
    else $error("return pc not from irq pair");
  a_restore_nmi: assert property (@(posedge clk)
    disable iff (rst)
    restore_en && np_set |->
      restore_pc == {6'h00, nmi_pc[25:1], 1'b0})
    else $error("return pc not from nmi pair");
endmodule
`default_nettype wire

// [tb/sxs_pipe_model.sv]
// Purpose: pipeline side model issuing register and event strobes
// Assumes: strobes rise 1 ns after a rising edge and last one cycle
// Notes:   released ld_data and next_pc show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module sxs_pipe_model
  import sxs_pkg::*;
(
  // clock and answer
  input  wire logic        clk,
  input  wire logic [31:0] rpc,
  input  wire logic        ren,
  // system register instructions
  output logic             ld_en,
  output logic             st_en,
  output logic      [4:0]  reg_num,
  output logic      [31:0] ld_data,
  // events
  output logic      [31:0] next_pc,
  output logic             irq_take,
  output logic             nmi_take,
  output logic      [15:0] exc_code,
  output logic             return_from_interrupt_instr_en,
  output logic             dbg_enter,
  output logic             dbg_return
);
  // idle at time zero
  initial begin
    {ld_en, st_en, reg_num, ld_data, next_pc, irq_take, nmi_take,
     exc_code, return_from_interrupt_instr_en, dbg_enter, dbg_return} = '0;
  end

  // a request starts just after an edge
  task automatic go;
    @(posedge clk);
    #1;
  endtask

  // taken at the edge, then strobes drop and data lines go stale
  task automatic fin;
    go();
    {ld_en, st_en, irq_take, nmi_take, return_from_interrupt_instr_en} = '0;
    {dbg_enter, dbg_return} = '0;
    ld_data = ~ld_data;
    next_pc = ~next_pc;
  endtask

  // numbers come from the tests; reserved ones only when a test asks
  task automatic ld(input logic [4:0] n, input logic [31:0] d);
    go();
    ld_en = 1'b1;
    reg_num = n;
    ld_data = d;
    fin();
  endtask

  task automatic st(input logic [4:0] n);
    go();
    st_en = 1'b1;
    reg_num = n;
    fin();
  endtask

  // pc values are even unless a test probes the dropped bit
  task automatic ev(input sxs_ev_e k, input logic [31:0] pc,
                    input logic [15:0] c);
    go();
    irq_take = (k == SXS_EV_IRQ);
    nmi_take = (k == SXS_EV_NMI);
    next_pc = pc;
    exc_code = c;
    fin();
  endtask

  // no nesting is enabled, so save pairs never need copying out
  task automatic ret(output logic [31:0] q, output logic e);
    go();
    return_from_interrupt_instr_en = 1'b1;
    @(posedge clk);
    q = rpc;
    e = ren;
    #1;
    return_from_interrupt_instr_en = 1'b0;
  endtask

  // debug window open or close
  task automatic dbg(input logic open);
    go();
    dbg_enter = open;
    dbg_return = !open;
    fin();
  endtask
endmodule
`default_nettype wire

// [tb/sxs_sysreg_tb.sv]
// Purpose: self-checking bench for the system register set
// Assumes: model tasks drive strobes; st_data read after the strobe
// Notes:   flag update path is driven once by the bench itself
`timescale 1ns/1ps
`default_nettype none
module sxs_sysreg_tb;
  import sxs_pkg::*;
  logic clk, rst, ld_en, st_en, irq_take, nmi_take, return_from_interrupt_instr_en;
  logic dbg_enter, dbg_return, flag_update_en, nmi_blocks, restore_en;
  logic [4:0]  reg_num;
  logic [15:0] exc_code;
  logic [31:0] ld_data, st_data, next_pc, flag_update, psw_out;
  logic [31:0] restore_pc, q;
  logic        qe;
  int          error_cnt, n_compared;
  logic [4:0]  nums [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h14};

  sxs_sysreg sxs_sysreg_inst (.clk(clk), .rst(rst), .ld_en(ld_en),
    .st_en(st_en), .reg_num(reg_num), .ld_data(ld_data),
    .st_data(st_data), .next_pc(next_pc), .irq_take(irq_take),
    .nmi_take(nmi_take), .exc_code(exc_code), .return_from_interrupt_instr_en(return_from_interrupt_instr_en),
    .dbg_enter(dbg_enter), .dbg_return(dbg_return),
    .flag_update(flag_update), .flag_update_en(flag_update_en),
    .psw_out(psw_out), .nmi_blocks(nmi_blocks),
    .restore_en(restore_en), .restore_pc(restore_pc));

  sxs_pipe_model sxs_pipe_model_inst (.clk(clk), .rpc(restore_pc),
    .ren(restore_en), .ld_en(ld_en), .st_en(st_en), .reg_num(reg_num),
    .ld_data(ld_data), .next_pc(next_pc), .irq_take(irq_take),
    .nmi_take(nmi_take),
    .exc_code(exc_code), .return_from_interrupt_instr_en(return_from_interrupt_instr_en), .dbg_enter(dbg_enter),
    .dbg_return(dbg_return));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run;
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // store instruction, then compare the registered read data
  task automatic rd(input logic [4:0] n, input logic [31:0] exp);
    sxs_pipe_model_inst.st(n);
    check(st_data, exp);
  endtask

  // about 120 cycles of traffic; 2000 leaves ample margin
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    flag_update = '0;
    flag_update_en = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    rd(SXS_NUM_PSW, SXS_PSW_RESET);
    // pipeline flag write; upper bits of the word stay clear
    @(posedge clk);
    #1 flag_update = 32'h0000_0f03;
    flag_update_en = 1'b1;
    @(posedge clk);
    #1 flag_update_en = 1'b0;
    check(psw_out, 32'h0000_0003);
    // write all, then read all, so aliased numbers show up
    foreach (nums[i]) begin
      sxs_pipe_model_inst.ld(nums[i], {24'h0, 8'ha0 | 8'(2*i)});
    end
    foreach (nums[i]) rd(nums[i], {24'h0, 8'ha0 | 8'(2*i)});
    // reserved upper bits of the irq and nmi pairs
    for (int i = 0; i < 4; i++) begin
      sxs_pipe_model_inst.ld(5'(i), {31'h7fff_ffff, i[0]});
      rd(5'(i), i[0] ? SXS_ST_MASK : 32'h03ff_fffe);
    end
    sxs_pipe_model_inst.ld(SXS_NUM_SRC, 32'hffff_ffff);
    rd(SXS_NUM_SRC, SXS_ZERO);
    sxs_pipe_model_inst.ld(5'h06, 32'h0000_0055);
    rd(5'h06, SXS_ZERO);
    sxs_pipe_model_inst.ld(5'h15, 32'h0000_0055);
    rd(5'h15, SXS_ZERO);
    // debug pair only inside the trap window
    sxs_pipe_model_inst.ld(SXS_NUM_DBG_PC, 32'h0000_0246);
    rd(SXS_NUM_DBG_PC, SXS_ZERO);
    sxs_pipe_model_inst.dbg(1'b1);
    // the load made outside the window must not have landed
    rd(SXS_NUM_DBG_PC, SXS_ZERO);
    sxs_pipe_model_inst.ld(SXS_NUM_DBG_PC, 32'h0000_0246);
    sxs_pipe_model_inst.ld(SXS_NUM_DBG_ST, 32'h0000_005a);
    rd(SXS_NUM_DBG_PC, 32'h0000_0246);
    rd(SXS_NUM_DBG_ST, 32'h0000_005a);
    sxs_pipe_model_inst.dbg(1'b0);
    rd(SXS_NUM_DBG_ST, SXS_ZERO);
    // status word load takes effect the cycle after the load
    sxs_pipe_model_inst.ld(SXS_NUM_PSW, 32'h0000_001f);
    check(psw_out, 32'h0000_001f);
    rd(SXS_NUM_PSW, 32'h0000_001f);
    // maskable interrupt saves into the irq pair
    sxs_pipe_model_inst.ev(SXS_EV_IRQ, 32'h0000_2468, 16'h0080);
    check(psw_out, 32'h0000_003f);
    rd(SXS_NUM_IRQ_PC, 32'h0000_2468);
    rd(SXS_NUM_IRQ_ST, 32'h0000_001f);
    rd(SXS_NUM_SRC, 32'h0000_0080);
    // nmi with carry bits above bit 25 on the pc
    sxs_pipe_model_inst.ev(SXS_EV_NMI, 32'hfc00_1356, 16'h0010);
    check(psw_out, 32'h0000_00bf);
    check({31'h0, nmi_blocks}, 32'h1);
    rd(SXS_NUM_NMI_PC, 32'h0000_1356);
    rd(SXS_NUM_NMI_ST, 32'h0000_003f);
    rd(SXS_NUM_IRQ_PC, 32'h0000_2468);
    rd(SXS_NUM_IRQ_ST, 32'h0000_001f);
    rd(SXS_NUM_SRC, 32'h0000_0010);
    // a further interrupt while the nmi is in service is ignored
    sxs_pipe_model_inst.ev(SXS_EV_IRQ, 32'h0000_0800, 16'h00a0);
    check(psw_out, 32'h0000_00bf);
    rd(SXS_NUM_IRQ_PC, 32'h0000_2468);
    rd(SXS_NUM_SRC, 32'h0000_0010);
    // odd saved pc: bit 0 must be dropped on return
    sxs_pipe_model_inst.ld(SXS_NUM_NMI_PC, 32'h0000_1357);
    sxs_pipe_model_inst.ret(q, qe);
    check(q, 32'h0000_1356);
    check({31'h0, qe}, 32'h1);
    check({31'h0, restore_en}, 32'h0);
    check(psw_out, 32'h0000_003f);
    sxs_pipe_model_inst.ret(q, qe);
    check(q, 32'h0000_2468);
    check({31'h0, qe}, 32'h1);
    check(psw_out, 32'h0000_001f);
    complete_run();
  end
endmodule
`default_nettype wire
